// ===== otps_pkg.sv
// package of the programming status block: register indices, field positions, timing
// assumes a 200 MHz aclk; registers sit at byte address four times their index
package otps_pkg;
  // ************************************************************
  // register indices (byte address = index * 4)
  // ************************************************************
  localparam logic [13:0] IDX_PROG_STAT  = 14'h0519;
  localparam logic [13:0] IDX_CUST1_STAT = 14'h051a;
  localparam logic [13:0] IDX_CUST2_STAT = 14'h051b;
  localparam logic [13:0] IDX_PROG_CTRL  = 14'h051c;
  localparam logic [13:0] IDX_UNLOCK     = 14'h051d;
  localparam logic [13:0] IDX_IRQ_STAT   = 14'h051e;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h051f;
  // ************************************************************
  // program_status fields
  // ************************************************************
  localparam int PS_UNLOCK = 7;
  localparam int PS_OT     = 6;
  localparam int PS_UV     = 5;
  localparam int PS_OV     = 4;
  localparam int PS_SUV    = 3;
  localparam int PS_SOV    = 2;
  localparam int PS_PERR   = 1;
  localparam int PS_DONE   = 0;
  // ************************************************************
  // page status fields
  // ************************************************************
  localparam int PG_LOADED = 7;
  localparam int PG_WARN   = 6;
  localparam int PG_LERR   = 5;
  localparam int PG_FMT    = 4;
  localparam int PG_VALID  = 3;
  localparam int PG_NOT_LOW  = 2;
  localparam int PG_NOT_HIGH = 1;
  localparam int PG_TRY    = 0;
  // ************************************************************
  // control, unlock and interrupt fields
  // ************************************************************
  localparam int CTRL_GO   = 0;
  localparam int CTRL_PAGE = 1;
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;  // arbitrary value
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_PERR  = 1;
  localparam int IRQ_SUPPLY = 2;
  localparam int IRQ_LERR  = 3;
  localparam int IRQ_WARN  = 4;
  localparam int IRQ_W     = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ       = 200;
  localparam int CHECK_TIME_US = 10;
  localparam int BURN_TIME_US  = 100;
  localparam int CHECK_CYCLES  = CHECK_TIME_US * CLK_MHZ;
  localparam int BURN_CYCLES   = BURN_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    OTPS_IDLE   = 2'b00,
    OTPS_CHECK  = 2'b01,
    OTPS_BURN   = 2'b10,
    OTPS_FINISH = 2'b11
  } otps_state_t;
endpackage

// ===== otps_top.sv
// programming status and lock logic of the one-time-programmable store, AXI4-Lite slave
// assumes supply and temperature monitor pins are asynchronous, load engine on aclk
//
// Operation
// - read-only unlock flag enables programming launches
// - write to other register relocks, clears unlock
// - launch command also clears unlock flag
// - low supply in burn sets fault, launch clears
// - high supply in burn sets fault, launch clears
// - bad launch sets page-setting fault, launch clears
// - done set on completion, cleared by launch
// - loaded flag marks page selected and loaded
// - load warning on single-error correction
// - load fault on double-bit error
// - format fault when ok flags without attempt
// - valid flag after a burn that ends with no supply trip, including one stopped by overtemperature
// - not-low flag one when no low supply
// - not-high flag zero on high supply, forces low
// - try flag set once an attempt passes the voltage check
// - page 2 status mirrors page 1 layout
`timescale 1ns/100ps
`default_nettype none
module otps_top #(
  parameter int unsigned BURN_CYCLES = otps_pkg::BURN_CYCLES
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // monitor pins, asynchronous
  input  wire logic        supply_low_pin,
  input  wire logic        supply_high_pin,
  input  wire logic        overtemp_pin,
  // load engine, same clock
  input  wire logic        load_done,
  input  wire logic        load_page,
  input  wire logic        load_sec_seen,
  input  wire logic        load_ded_seen,
  // programming drive and interrupt
  output logic             burn_enable,
  output logic             burn_page,
  output logic             irq
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    return a[15:2] == idx;
  endfunction
  // format fault: a supply verdict recorded on a page that was never tried
  function automatic logic fmt_of(input logic [7:0] p);
    return (p[otps_pkg::PG_NOT_LOW] | p[otps_pkg::PG_NOT_HIGH]) & ~p[otps_pkg::PG_TRY];
  endfunction
  function automatic logic [7:0] page_view(input logic [7:0] p);
    logic [7:0] v;
    v = p;
    v[otps_pkg::PG_FMT] = fmt_of(p);
    return v;
  endfunction

  logic [15:0] aw_addr_ff;
  logic        awready_ff;
  logic [7:0]  w_byte_ff;
  logic        w_lane_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        unlock_ff;
  logic [6:0]  flags_ff;
  logic [7:0]  page_ff [2];
  localparam int IRQ_W_L = otps_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_ff;
  logic [IRQ_W_L-1:0] irq_mask_ff;
  logic        irq_ff;
  logic [2:0]  s1_ff, s2_ff, s3_ff, mon_ff;
  otps_pkg::otps_state_t state_ff;
  logic [15:0] cnt_ff;
  logic        page_sel_ff;
  logic        uv_seen_ff, ov_seen_ff;

  // ************************************************************
  // axi write channel
  // ************************************************************
  logic wr_fire, rd_fire, mapped_w, mapped_r;
  assign wr_fire = ce & ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign rd_fire = ce & arvalid & arready_ff;
  assign mapped_w = hit(aw_addr_ff, otps_pkg::IDX_PROG_CTRL) | hit(aw_addr_ff, otps_pkg::IDX_UNLOCK)
                  | hit(aw_addr_ff, otps_pkg::IDX_IRQ_MASK);
  assign mapped_r = mapped_w | hit(araddr, otps_pkg::IDX_PROG_STAT)
                  | hit(araddr, otps_pkg::IDX_CUST1_STAT) | hit(araddr, otps_pkg::IDX_CUST2_STAT)
                  | hit(araddr, otps_pkg::IDX_IRQ_STAT);

  // address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_addr_ff <= 16'h0000;
      w_byte_ff  <= otps_pkg::RST_BYTE;
      w_lane_ff  <= 1'b0;
    end else if (ce) begin
      if (awvalid & awready_ff) begin
        awready_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end else if (wr_fire) begin
        awready_ff <= 1'b1;
      end
      if (wvalid & wready_ff) begin
        wready_ff <= 1'b0;
        w_byte_ff <= wdata[7:0];
        w_lane_ff <= wstrb[0];
      end else if (wr_fire) begin
        wready_ff <= 1'b1;
      end
    end
  end

  // response; read-only and unmapped words answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= otps_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= mapped_w ? otps_pkg::RESP_OKAY : otps_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  logic wr_lo, wr_ctrl, wr_key, wr_mask, go_wr, reject, start;
  assign wr_lo   = wr_fire & w_lane_ff;
  assign wr_ctrl = wr_lo & hit(aw_addr_ff, otps_pkg::IDX_PROG_CTRL);
  assign wr_key  = wr_lo & hit(aw_addr_ff, otps_pkg::IDX_UNLOCK) & (w_byte_ff == otps_pkg::UNLOCK_KEY);
  assign wr_mask = wr_lo & hit(aw_addr_ff, otps_pkg::IDX_IRQ_MASK);
  assign go_wr   = wr_ctrl & w_byte_ff[otps_pkg::CTRL_GO];
  // a bad request, a used or malformed page, or a busy engine is refused
  assign reject  = ~unlock_ff | (state_ff != otps_pkg::OTPS_IDLE)
                 | page_ff[w_byte_ff[otps_pkg::CTRL_PAGE]][otps_pkg::PG_TRY]
                 | fmt_of(page_ff[w_byte_ff[otps_pkg::CTRL_PAGE]]);
  assign start   = go_wr & ~reject;

  // ************************************************************
  // axi read channel
  // ************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = otps_pkg::RST_BYTE;
    if (hit(araddr, otps_pkg::IDX_PROG_STAT))  rd_byte = {unlock_ff, flags_ff};
    if (hit(araddr, otps_pkg::IDX_CUST1_STAT)) rd_byte = page_view(page_ff[0]);
    if (hit(araddr, otps_pkg::IDX_CUST2_STAT)) rd_byte = page_view(page_ff[1]);
    if (hit(araddr, otps_pkg::IDX_IRQ_STAT))   rd_byte = {3'h0, irq_stat_ff};
    if (hit(araddr, otps_pkg::IDX_IRQ_MASK))   rd_byte = {3'h0, irq_mask_ff};
  end

  // one read outstanding; arready drops while the answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= otps_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= {24'h00_0000, rd_byte};
        rresp_ff   <= mapped_r ? otps_pkg::RESP_OKAY : otps_pkg::RESP_SLVERR;
      end else if (rvalid_ff & rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // a level counts only once the second and third stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff  <= 3'h0;
      s2_ff  <= 3'h0;
      s3_ff  <= 3'h0;
      mon_ff <= 3'h0;
    end else if (ce) begin
      s1_ff <= {overtemp_pin, supply_high_pin, supply_low_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 3; i++) begin
        if (s2_ff[i] == s3_ff[i]) mon_ff[i] <= s3_ff[i];
      end
    end
  end
  logic mon_low, mon_high, mon_hot;
  assign mon_low  = mon_ff[0];
  assign mon_high = mon_ff[1];
  assign mon_hot  = mon_ff[2];

  // ************************************************************
  // programming sequencer
  // ************************************************************
  logic check_end, burn_end, check_abort, burn_abort;
  assign check_end   = cnt_ff == 16'(otps_pkg::CHECK_CYCLES - 1);
  assign burn_end    = cnt_ff == 16'(BURN_CYCLES - 1);
  assign check_abort = (state_ff == otps_pkg::OTPS_CHECK) & (mon_low | mon_high | mon_hot);
  assign burn_abort  = (state_ff == otps_pkg::OTPS_BURN) & (mon_low | mon_high | mon_hot);

  // voltage check first, then the burn; any monitor trip ends the attempt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= otps_pkg::OTPS_IDLE;
      cnt_ff      <= 16'h0000;
      page_sel_ff <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        otps_pkg::OTPS_IDLE: begin
          cnt_ff <= 16'h0000;
          if (start) begin
            state_ff    <= otps_pkg::OTPS_CHECK;
            page_sel_ff <= w_byte_ff[otps_pkg::CTRL_PAGE];
          end
        end
        otps_pkg::OTPS_CHECK: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (check_abort) state_ff <= otps_pkg::OTPS_IDLE;
          else if (check_end) begin
            state_ff <= otps_pkg::OTPS_BURN;
            cnt_ff   <= 16'h0000;
          end
        end
        otps_pkg::OTPS_BURN: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (burn_abort) state_ff <= otps_pkg::OTPS_FINISH;
          else if (burn_end) state_ff <= otps_pkg::OTPS_FINISH;
        end
        otps_pkg::OTPS_FINISH: state_ff <= otps_pkg::OTPS_IDLE;
        default: state_ff <= otps_pkg::OTPS_IDLE;
      endcase
    end
  end

  // supply trips seen during the burn; a high supply also forces low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_seen_ff <= 1'b0;
      ov_seen_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == otps_pkg::OTPS_IDLE) begin
        uv_seen_ff <= 1'b0;
        ov_seen_ff <= 1'b0;
      end else if (burn_abort) begin
        uv_seen_ff <= mon_low | mon_high;
        ov_seen_ff <= mon_high;
      end
    end
  end

  // ************************************************************
  // unlock and program_status
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_ff <= 1'b0;
    end else if (ce) begin
      if (wr_key) unlock_ff <= 1'b1;
      else if (wr_fire & ~hit(aw_addr_ff, otps_pkg::IDX_PROG_CTRL)) unlock_ff <= 1'b0;
      else if (go_wr) unlock_ff <= 1'b0;
    end
  end

  // launch clears the sticky flags; a same-cycle set wins
  logic [6:0] nxt_flags;
  always_comb begin
    nxt_flags = go_wr ? 7'h00 : flags_ff;
    if (go_wr & reject) nxt_flags[otps_pkg::PS_PERR] = 1'b1;
    if ((check_abort | burn_abort) & mon_hot) nxt_flags[otps_pkg::PS_OT] = 1'b1;
    if (burn_abort & (mon_low | mon_high)) nxt_flags[otps_pkg::PS_UV] = 1'b1;
    if (burn_abort & mon_high) nxt_flags[otps_pkg::PS_OV] = 1'b1;
    if (check_abort & mon_low) nxt_flags[otps_pkg::PS_SUV] = 1'b1;
    if (check_abort & mon_high) nxt_flags[otps_pkg::PS_SOV] = 1'b1;
    if (state_ff == otps_pkg::OTPS_FINISH) nxt_flags[otps_pkg::PS_DONE] = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_ff <= 7'h00;
    else if (ce) flags_ff <= nxt_flags;
  end

  // ************************************************************
  // per-page status, reads leave it alone
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_ff[0] <= otps_pkg::RST_BYTE;
      page_ff[1] <= otps_pkg::RST_BYTE;
    end else if (ce) begin
      if (load_done) begin
        page_ff[load_page][otps_pkg::PG_LOADED] <= 1'b1;
        page_ff[load_page][otps_pkg::PG_WARN]   <= load_sec_seen;
        page_ff[load_page][otps_pkg::PG_LERR]   <= load_ded_seen;
      end
      if ((state_ff == otps_pkg::OTPS_CHECK) & check_end & ~check_abort) begin
        page_ff[page_sel_ff][otps_pkg::PG_TRY] <= 1'b1;
      end
      if (state_ff == otps_pkg::OTPS_FINISH) begin
        page_ff[page_sel_ff][otps_pkg::PG_NOT_LOW]  <= ~uv_seen_ff;
        page_ff[page_sel_ff][otps_pkg::PG_NOT_HIGH] <= ~ov_seen_ff;
        page_ff[page_sel_ff][otps_pkg::PG_VALID] <= ~uv_seen_ff & ~ov_seen_ff;
      end
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  logic [IRQ_W_L-1:0] ev;
  logic               stat_rd;
  assign ev[otps_pkg::IRQ_DONE]   = state_ff == otps_pkg::OTPS_FINISH;
  assign ev[otps_pkg::IRQ_PERR]   = go_wr & reject;
  assign ev[otps_pkg::IRQ_SUPPLY] = check_abort | burn_abort;
  assign ev[otps_pkg::IRQ_LERR]   = load_done & load_ded_seen;
  assign ev[otps_pkg::IRQ_WARN]   = load_done & load_sec_seen;
  assign stat_rd = rd_fire & hit(araddr, otps_pkg::IDX_IRQ_STAT);

  // read clears, but an event in the same cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else if (ce) begin
      irq_stat_ff <= (stat_rd ? '0 : irq_stat_ff) | ev;
      if (wr_mask) irq_mask_ff <= w_byte_ff[IRQ_W_L-1:0];
      irq_ff <= |(((stat_rd ? '0 : irq_stat_ff) | ev) & (wr_mask ? w_byte_ff[IRQ_W_L-1:0] : irq_mask_ff));
    end
  end

  // drive outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burn_enable <= 1'b0;
      burn_page   <= 1'b0;
    end else if (ce) begin
      burn_enable <= (state_ff == otps_pkg::OTPS_BURN) & ~burn_abort & ~burn_end;
      burn_page   <= page_sel_ff;
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign irq     = irq_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RELOCK: assert property (
    wr_fire & ~wr_key & ~hit(aw_addr_ff, otps_pkg::IDX_PROG_CTRL) |=> ~unlock_ff)
    else $error("unlock survived foreign write");
  AST_GO_LOCK: assert property (go_wr |=> ~unlock_ff) else $error("unlock survived launch");
  AST_START_NEEDS_UNLOCK: assert property (
    ce & (state_ff == otps_pkg::OTPS_IDLE) ##1 (state_ff == otps_pkg::OTPS_CHECK)
    |-> $past(unlock_ff)) else $error("start while locked");
  AST_PERR: assert property (go_wr & ~unlock_ff |=> flags_ff[otps_pkg::PS_PERR])
    else $error("page fault missing");
  AST_GO_CLEAR: assert property (go_wr & ~reject |=>
    flags_ff[otps_pkg::PS_DONE] == 1'b0 && flags_ff[otps_pkg::PS_UV] == 1'b0)
    else $error("launch left flags");
  AST_UV: assert property (ce & burn_abort & mon_low & ~go_wr |=>
    flags_ff[otps_pkg::PS_UV]) else $error("low supply not flagged");
  AST_OV: assert property (ce & burn_abort & mon_high |=> flags_ff[otps_pkg::PS_OV]
    ##1 ~page_ff[page_sel_ff][otps_pkg::PG_NOT_LOW]) else $error("high supply");
  AST_SOV: assert property (ce & check_abort & mon_high |=> flags_ff[otps_pkg::PS_SOV]
    && state_ff == otps_pkg::OTPS_IDLE) else $error("check high not flagged");
  AST_LOAD: assert property (ce & load_done & load_ded_seen |=>
    page_ff[$past(load_page)][otps_pkg::PG_LERR]
    && page_ff[$past(load_page)][otps_pkg::PG_LOADED]) else $error("load fault missing");
  AST_FMT: assert property (go_wr & fmt_of(page_ff[w_byte_ff[otps_pkg::CTRL_PAGE]]) |=>
    flags_ff[otps_pkg::PS_PERR]) else $error("malformed page launched");
  AST_VALID: assert property (page_ff[0][otps_pkg::PG_VALID] |->
    page_ff[0][otps_pkg::PG_TRY] && page_ff[0][otps_pkg::PG_NOT_LOW])
    else $error("valid without attempt");
  AST_RD_STABLE: assert property (
    rd_fire & ~stat_rd & ~load_done & state_ff == otps_pkg::OTPS_IDLE & ~wr_fire
    |=> $stable(page_ff[0]) && $stable(flags_ff)) else $error("read side effect");

  COV_DONE: cover property (state_ff == otps_pkg::OTPS_FINISH ##1 flags_ff[otps_pkg::PS_DONE]);
  COV_REJECT: cover property (go_wr & reject);
  COV_LOAD: cover property (load_done & load_sec_seen);
  COV_IRQ: cover property (irq_ff);
endmodule // otps_top
`default_nettype wire

// ===== otps_top_tb.sv
// testbench of the programming status block: axi4-lite tasks and directed sequences
// assumes otps_pkg compiled first; the design carries its own assertions
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module otps_top_tb;
  localparam int BURN = 50;  // short burn keeps the run brief
  logic        aclk = 0, aresetn = 0, ce = 1;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, burn_enable, burn_page;
  logic [1:0]  bresp, rresp, r;
  logic        sup_lo = 0, sup_hi = 0, ot = 0;
  logic        ld_done = 0, ld_page = 0, ld_sec = 0, ld_ded = 0;
  logic [7:0]  d;
  int          errors = 0, n_compared = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  otps_top #(.BURN_CYCLES(BURN)) DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .supply_low_pin(sup_lo), .supply_high_pin(sup_hi),
    .overtemp_pin(ot), .load_done(ld_done), .load_page(ld_page), .load_sec_seen(ld_sec),
    .load_ded_seen(ld_ded), .burn_enable(burn_enable), .burn_page(burn_page), .irq(irq));
  // ************************************************************
  // closing and hang guard
  // ************************************************************
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a stuck handshake would otherwise hang the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  // ************************************************************
  // bus tasks: address, data and ready held until each handshake
  // ************************************************************
  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {idx, 2'b00}; awvalid <= 1; wdata <= {24'h0, v}; wstrb <= 4'hf;
    wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0; r = bresp;
  endtask
  task automatic rd(input logic [13:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00}; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0; r = rresp; d = rdata[7:0];
  endtask
  // read and compare the selected bits of a register
  task automatic chk(input logic [13:0] idx, input logic [7:0] m, input logic [7:0] e);
    rd(idx);
    `CHK(d & m, e)
  endtask
  task automatic wait_burn(input logic v, input int lim);
    int n;
    n = 0;
    while (burn_enable !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    `CHK(burn_enable, v)
  endtask
  // single-cycle load completion from the load engine
  task automatic load(input logic sec, input logic ded);
    @(posedge aclk);
    ld_done <= 1; ld_page <= 0; ld_sec <= sec; ld_ded <= ded;
    @(posedge aclk);
    ld_done <= 0; ld_sec <= 0; ld_ded <= 0;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h00);
    chk(otps_pkg::IDX_CUST1_STAT, 8'hff, 8'h00);
    chk(14'h0600, 8'hff, 8'h00);
    `CHK(r, otps_pkg::RESP_SLVERR)
    // locked launch is refused and raises the unmasked interrupt
    wr(otps_pkg::IDX_IRQ_MASK, 8'h02);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h01);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h02);
    `CHK(irq, 1'b1)
    chk(otps_pkg::IDX_IRQ_STAT, 8'hff, 8'h02);
    `CHK(irq, 1'b0)
    chk(otps_pkg::IDX_IRQ_STAT, 8'hff, 8'h00);
    // unlock, then relock by a write elsewhere
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h82);
    wr(otps_pkg::IDX_IRQ_MASK, 8'h00);
    `CHK(r, otps_pkg::RESP_OKAY)
    `CHK({awready, wready, arready}, 3'b111)
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h02);
    // a refused write to a read-only word still relocks and stores nothing
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    wr(otps_pkg::IDX_CUST1_STAT, 8'hff);
    `CHK(r, otps_pkg::RESP_SLVERR)
    chk(otps_pkg::IDX_PROG_STAT, 8'h80, 8'h00);
    chk(otps_pkg::IDX_CUST1_STAT, 8'hff, 8'h00);
    // clean programming of page 1
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h01);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h00);
    wait_burn(1'b1, otps_pkg::CHECK_CYCLES + 50);
    `CHK(burn_page, 1'b0)
    // enable low freezes the burn well past its length
    ce <= 0;
    repeat (100) @(posedge aclk);
    `CHK(burn_enable, 1'b1)
    ce <= 1;
    wait_burn(1'b0, BURN + 50);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h01);
    chk(otps_pkg::IDX_CUST1_STAT, 8'hff, 8'h0f);
    load(1'b1, 1'b0);
    chk(otps_pkg::IDX_CUST1_STAT, 8'hff, 8'hcf);
    load(1'b0, 1'b1);
    chk(otps_pkg::IDX_CUST1_STAT, 8'hff, 8'haf);
    // second attempt on a tried page is refused, done cleared
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h01);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h02);
    // high supply in the check phase on page 2
    sup_hi <= 1;
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h03);
    repeat (50) @(posedge aclk);
    sup_hi <= 0;
    chk(otps_pkg::IDX_PROG_STAT, 8'h04, 8'h04);
    `CHK(burn_enable, 1'b0)
    chk(otps_pkg::IDX_CUST2_STAT, 8'hff, 8'h00);
    // high supply in the burn phase on page 2
    wr(otps_pkg::IDX_UNLOCK, otps_pkg::UNLOCK_KEY);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h03);
    wait_burn(1'b1, otps_pkg::CHECK_CYCLES + 50);
    `CHK(burn_page, 1'b1)
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h00);
    sup_hi <= 1;
    wait_burn(1'b0, BURN + 50);
    sup_hi <= 0;
    chk(otps_pkg::IDX_PROG_STAT, 8'h30, 8'h30);
    chk(otps_pkg::IDX_CUST2_STAT, 8'h07, 8'h01);
    wr(otps_pkg::IDX_PROG_CTRL, 8'h01);
    chk(otps_pkg::IDX_PROG_STAT, 8'hff, 8'h02);
    close_out();
  end
endmodule  // otps_top_tb
`default_nettype wire
